// ==== hdl/rscl_defs.vh ====
// rscl_defs.vh: constants for the reset strap configuration latch
// assumes inclusion by bare name from the design file
`ifndef RSCL_DEFS_VH
`define RSCL_DEFS_VH
`define RSCL_READBACK_OFS 8'hEC
`define RSCL_BIT_INT_EN 26
`define RSCL_BIT_ROM_EN 25
`define RSCL_BIT_CHAN_BYP 24
`define RSCL_BIT_VGA_EN 23
`define RSCL_BIT_ROM_SIZE 22
`define RSCL_BIT_VIDCLK_BYP 21
`define RSCL_BIT_PORT_SRC 20
`define RSCL_BIT_TV_ABSENT 19
`define RSCL_BIT_TV_STD 18
`define RSCL_BIT_PORT_ABSENT 17
`define RSCL_BIT_PAD_PCI 16
`define RSCL_BIT_MCLK_BYP 15
`define RSCL_RESET_VALUE 27'h7FFFFFF
`define RSCL_BUS_AGP66 3'h7
`define RSCL_BUS_AGP133 3'h6
`define RSCL_BUS_PCI33 3'h5
`define RSCL_BUS_PCI66 3'h4
`define RSCL_VIDEO_MODULE_IF_MODE_A 2'h1
`define RSCL_VIDEO_MODULE_IF_MODE_B 2'h0
`define RSCL_EARLY_REVS 2'h2
`endif

// ==== hdl/rscl_strap_latch.v ====
// rscl_strap_latch.v: captures board strap levels at reset release and
// decodes them into the device's fixed operating options.
// assumes strap pins are stable around the rising edge of i_arst_n.
//
// Summary of operation
// (RULE1) capture straps at reset rise, read back
// (RULE2) interrupt strap low disables interrupt, line register
// (RULE3) rom select strap gates rom decode, bar
// (RULE4) serial strap low selects channel bypass mode
// (RULE5) addr15 strap low routes clock pin to system clock
// (RULE6) host bus field decodes agp or pci modes
// (RULE7) video module field selects off, mode a, b
// (RULE8) route bit picks feature connector output lines
// (RULE9) enable bit enables feature connector after reset
// (RULE10) vga strap enables vga, mirrors subclass bit 7
// (RULE11) rom size strap picks 64k or 32k decode
// (RULE12) strap low routes serial clock to video clock
// (RULE13) port source bit picks input data lines
// (RULE14) tv absent bit, mirrored in status two bit 0
// (RULE15) tv standard bit gives ntsc or pal
// (RULE16) port absent bit, mirrored in status one bit 0
// (RULE17) pad bit picks pci or agp pads
// (RULE18) early revisions swap rom size, clock bypass
// (RULE19) latched values hold until next reset, read only
`timescale 1ns/1ps
`include "rscl_defs.vh"
module rscl_strap_latch
#(
  parameter [1:0] SILICON_REV = 2'h2 // arbitrary revision index
)
(
  input wire i_clk_sys,
  input wire i_arst_n,
  input wire [26:0] i_strap_pins,
  input wire [7:0] i_cfg_addr,
  input wire i_cfg_rd,
  output reg [31:0] o_cfg_rdata,
  output reg o_int_allowed,
  output reg o_int_line_enable,
  output reg o_rom_decode_enable,
  output reg o_rom_bar_enable,
  output reg o_rom_size_64k,
  output reg o_rom_bar_bit15,
  output reg o_mem_channel_bypass,
  output reg o_mem_clock_test_bypass,
  output reg o_video_clock_test_bypass,
  output reg [2:0] o_host_bus_select,
  output reg o_bus_agp,
  output reg o_bus_agp_133,
  output reg o_bus_pci_66,
  output reg o_bus_reserved,
  output reg [1:0] o_video_module_if_mode,
  output reg o_vmi_enable,
  output reg o_video_module_if_mode_a,
  output reg o_feature_conn_route,
  output reg o_feature_conn_enable,
  output reg o_vga_enable,
  output reg o_subclass_bit7,
  output reg o_periph_port_data_source,
  output reg o_tv_encoder_absent,
  output reg o_tv_standard_select,
  output reg o_periph_port_absent,
  output reg o_periph_status_one,
  output reg o_periph_status_zero,
  output reg o_pad_pci
);

////////////////////////////////////////////////////////////////////////
// strap capture: pins sampled by two stages, latched after reset release and held until next reset
reg [26:0] sync1_q;
reg [26:0] sync2_q;
reg [26:0] strap_q;
reg cap_done_q;

// synchroniser keeps sampling during reset, so the capture sees the pins
always @(posedge i_clk_sys)
begin
  sync1_q <= i_strap_pins;
  sync2_q <= sync1_q;
end

// one-time capture after release, frozen until next reset
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    strap_q <= `RSCL_RESET_VALUE;
    cap_done_q <= 1'b0;
  end
  else if (!cap_done_q)
  begin
    strap_q <= sync2_q; // [RULE1]
    cap_done_q <= 1'b1; // [RULE19]
  end
end

////////////////////////////////////////////////////////////////////////
// revision swap of rom size and memory clock bypass straps
wire early_rev;
wire eff_rom_size;
wire eff_mclk_byp;

assign early_rev = (SILICON_REV < `RSCL_EARLY_REVS);
assign eff_rom_size = early_rev ? strap_q[`RSCL_BIT_MCLK_BYP] :
  strap_q[`RSCL_BIT_ROM_SIZE]; // [RULE18]
assign eff_mclk_byp = early_rev ? strap_q[`RSCL_BIT_ROM_SIZE] :
  strap_q[`RSCL_BIT_MCLK_BYP]; // [RULE18]

////////////////////////////////////////////////////////////////////////
// interrupt request and line register gating
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_int_allowed <= 1'b1;
    o_int_line_enable <= 1'b1;
  end
  else
  begin
    o_int_allowed <= strap_q[`RSCL_BIT_INT_EN]; // [RULE2]
    o_int_line_enable <= strap_q[`RSCL_BIT_INT_EN]; // [RULE2]
  end
end

// rom decode and rom base register gating
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_rom_decode_enable <= 1'b1;
    o_rom_bar_enable <= 1'b1;
  end
  else
  begin
    o_rom_decode_enable <= strap_q[`RSCL_BIT_ROM_EN]; // [RULE3]
    o_rom_bar_enable <= strap_q[`RSCL_BIT_ROM_EN]; // [RULE3]
  end
end

// rom window size and its base register mirror
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_rom_size_64k <= 1'b1;
    o_rom_bar_bit15 <= 1'b1;
  end
  else
  begin
    o_rom_size_64k <= eff_rom_size; // [RULE11]
    o_rom_bar_bit15 <= eff_rom_size; // [RULE11]
  end
end

// memory channel test bypass, active when the strap is low
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_mem_channel_bypass <= 1'b0;
  end
  else
  begin
    o_mem_channel_bypass <= ~strap_q[`RSCL_BIT_CHAN_BYP]; // [RULE4]
  end
end

// memory clock pin bypass, active when the strap is low
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_mem_clock_test_bypass <= 1'b0;
  end
  else
  begin
    o_mem_clock_test_bypass <= ~eff_mclk_byp; // [RULE5]
  end
end

// video clock pin bypass, active when the strap is low
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_video_clock_test_bypass <= 1'b0;
  end
  else
  begin
    o_video_clock_test_bypass <= ~strap_q[`RSCL_BIT_VIDCLK_BYP]; // [RULE12]
  end
end

// host bus type and speed decode, low codes reserved
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_host_bus_select <= 3'h7;
    o_bus_agp <= 1'b1;
    o_bus_agp_133 <= 1'b0;
    o_bus_pci_66 <= 1'b0;
    o_bus_reserved <= 1'b0;
  end
  else
  begin
    o_host_bus_select <= strap_q[6:4]; // [RULE6]
    o_bus_agp <= (strap_q[6:4] == `RSCL_BUS_AGP66) ||
      (strap_q[6:4] == `RSCL_BUS_AGP133); // [RULE6]
    o_bus_agp_133 <= (strap_q[6:4] == `RSCL_BUS_AGP133); // [RULE6]
    o_bus_pci_66 <= (strap_q[6:4] == `RSCL_BUS_PCI66); // [RULE6]
    o_bus_reserved <= ~strap_q[6]; // [RULE6]
  end
end

// video module interface: off, mode a or mode b
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_video_module_if_mode <= 2'h3;
    o_vmi_enable <= 1'b0;
    o_video_module_if_mode_a <= 1'b0;
  end
  else
  begin
    o_video_module_if_mode <= strap_q[3:2]; // [RULE7]
    o_vmi_enable <= ~strap_q[3]; // [RULE7]
    o_video_module_if_mode_a <= (strap_q[3:2] == `RSCL_VIDEO_MODULE_IF_MODE_A); // [RULE7]
  end
end

// feature connector output line routing
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_feature_conn_route <= 1'b1;
  end
  else
  begin
    o_feature_conn_route <= strap_q[1]; // [RULE8]
  end
end

// feature connector enable out of reset
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_feature_conn_enable <= 1'b1;
  end
  else
  begin
    o_feature_conn_enable <= strap_q[0]; // [RULE9]
  end
end

// vga enable and subclass mirror
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_vga_enable <= 1'b1;
    o_subclass_bit7 <= 1'b1;
  end
  else
  begin
    o_vga_enable <= strap_q[`RSCL_BIT_VGA_EN]; // [RULE10]
    o_subclass_bit7 <= strap_q[`RSCL_BIT_VGA_EN]; // [RULE10]
  end
end

// peripheral port input data source
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_periph_port_data_source <= 1'b1;
  end
  else
  begin
    o_periph_port_data_source <= strap_q[`RSCL_BIT_PORT_SRC]; // [RULE13]
  end
end

// tv encoder absence and its status mirror
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_tv_encoder_absent <= 1'b1;
    o_periph_status_one <= 1'b1;
  end
  else
  begin
    o_tv_encoder_absent <= strap_q[`RSCL_BIT_TV_ABSENT]; // [RULE14]
    o_periph_status_one <= strap_q[`RSCL_BIT_TV_ABSENT]; // [RULE14]
  end
end

// tv standard of the attached encoder
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_tv_standard_select <= 1'b1;
  end
  else
  begin
    o_tv_standard_select <= strap_q[`RSCL_BIT_TV_STD]; // [RULE15]
  end
end

// peripheral port absence and its status mirror
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_periph_port_absent <= 1'b1;
    o_periph_status_zero <= 1'b1;
  end
  else
  begin
    o_periph_port_absent <= strap_q[`RSCL_BIT_PORT_ABSENT]; // [RULE16]
    o_periph_status_zero <= strap_q[`RSCL_BIT_PORT_ABSENT]; // [RULE16]
  end
end

// host pad characteristics
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
  begin
    o_pad_pci <= 1'b1;
  end
  else
  begin
    o_pad_pci <= strap_q[`RSCL_BIT_PAD_PCI]; // [RULE17]
  end
end

////////////////////////////////////////////////////////////////////////
// configuration readback, read only, other offsets read zero
always @(posedge i_clk_sys or negedge i_arst_n)
begin
  if (!i_arst_n)
    o_cfg_rdata <= 32'h00000000;
  else if (i_cfg_rd && (i_cfg_addr == `RSCL_READBACK_OFS))
    o_cfg_rdata <= {5'h00, strap_q}; // [RULE1] [RULE19]
  else if (i_cfg_rd)
    o_cfg_rdata <= 32'h00000000;
end

endmodule // rscl_strap_latch

// ==== verif/rscl_strap_board.sv ====
// board strap model: internal pull-ups with fitted pull-downs
// assumes the fit mask is set before reset release
`timescale 1ns/1ps
module rscl_strap_board
(
  input logic [26:0] i_pulldown_fit,
  output logic [26:0] o_strap_pins
);
  // pull-up reads 1 unless a pull-down is fitted
  assign o_strap_pins = ~i_pulldown_fit;
endmodule // rscl_strap_board

// ==== verif/rscl_strap_latch_properties.sv ====
// checker: readback and decode relations of the strap latch
// assumes binding to every rscl_strap_latch instance, revision swap included
`timescale 1ns/1ps
module rscl_properties
(
  input logic i_clk_sys,
  input logic i_arst_n,
  input logic [7:0] i_cfg_addr,
  input logic i_cfg_rd,
  input logic [31:0] o_cfg_rdata,
  input logic o_int_allowed,
  input logic o_mem_channel_bypass,
  input logic [2:0] o_host_bus_select,
  input logic o_bus_agp_133,
  input logic [1:0] o_video_module_if_mode,
  input logic o_vmi_enable,
  input logic o_vga_enable,
  input logic o_subclass_bit7
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////////////////////
  // read of the readback offset
  sequence rd_ec;
    i_cfg_rd && i_cfg_addr == 8'hEC;
  endsequence
  AST_RD_TOP: assert property (
    rd_ec |=> o_cfg_rdata[31:27] == 5'h00)
    else $error("readback top bits set");
  AST_INT: assert property (
    rd_ec |=> o_int_allowed == o_cfg_rdata[26])
    else $error("interrupt gate differs");
  AST_CHAN: assert property (
    rd_ec |=> o_mem_channel_bypass != o_cfg_rdata[24])
    else $error("channel bypass differs");
  AST_BUS: assert property (
    rd_ec |=> o_host_bus_select == o_cfg_rdata[6:4])
    else $error("bus field differs");
  AST_AGP133: assert property (
    o_bus_agp_133 == (o_host_bus_select == 3'h6))
    else $error("agp 133 decode wrong");
  AST_VMI: assert property (
    o_vmi_enable != o_video_module_if_mode[1])
    else $error("module interface enable wrong");
  AST_VGA: assert property (
    rd_ec |=> o_subclass_bit7 == o_cfg_rdata[23] &&
      o_vga_enable == o_cfg_rdata[23])
    else $error("vga mirror differs");
  AST_HOLD: assert property (
    !i_cfg_rd |=> $stable(o_cfg_rdata))
    else $error("readback moved without read");
endmodule // rscl_properties

// ==== verif/test_rscl_strap_latch.sv ====
// testbench: strap capture, decode and readback
// assumes board model on the pins, 50 MHz clock
`timescale 1ns/1ps
module test_rscl_strap_latch;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_cfg_addr = 8'h00;
  logic i_cfg_rd = 1'b0;
  logic [26:0] fit = 27'h0000000;
  logic [26:0] p;
  logic [31:0] rd;
  int n_fail = 0;
  int n_tests = 0;
  logic [26:0] pat [6] = '{27'h7FFFFFF, 27'h0000000, 27'h5555555,
    27'h2AAAAAA, 27'h1234567, 27'h00000C8};
  wire [26:0] i_strap_pins;
  wire [31:0] o_cfg_rdata;
  wire [2:0] o_host_bus_select;
  wire [1:0] o_video_module_if_mode;
  wire o_int_allowed, o_int_line_enable, o_rom_decode_enable;
  wire o_rom_bar_enable, o_rom_size_64k, o_rom_bar_bit15, o_bus_agp;
  wire o_mem_channel_bypass, o_mem_clock_test_bypass, o_bus_agp_133;
  wire o_video_clock_test_bypass, o_bus_pci_66, o_bus_reserved;
  wire o_vmi_enable, o_video_module_if_mode_a, o_feature_conn_route, o_pad_pci;
  wire o_feature_conn_enable, o_vga_enable, o_subclass_bit7;
  wire o_periph_port_data_source, o_tv_encoder_absent;
  wire o_tv_standard_select, o_periph_port_absent;
  wire o_periph_status_one, o_periph_status_zero;
  wire early_rom_64k, early_mclk_byp;
  rscl_strap_latch i_dut (.*);
  // early revision: rom size and memory clock bypass swapped
  rscl_strap_latch #(.SILICON_REV(2'h0)) i_dut_early
  (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_strap_pins(i_strap_pins),
    .i_cfg_addr(i_cfg_addr),
    .i_cfg_rd(i_cfg_rd),
    .o_cfg_rdata(),
    .o_int_allowed(),
    .o_int_line_enable(),
    .o_rom_decode_enable(),
    .o_rom_bar_enable(),
    .o_rom_size_64k(early_rom_64k),
    .o_rom_bar_bit15(),
    .o_mem_channel_bypass(),
    .o_mem_clock_test_bypass(early_mclk_byp),
    .o_video_clock_test_bypass(),
    .o_host_bus_select(),
    .o_bus_agp(),
    .o_bus_agp_133(),
    .o_bus_pci_66(),
    .o_bus_reserved(),
    .o_video_module_if_mode(),
    .o_vmi_enable(),
    .o_video_module_if_mode_a(),
    .o_feature_conn_route(),
    .o_feature_conn_enable(),
    .o_vga_enable(),
    .o_subclass_bit7(),
    .o_periph_port_data_source(),
    .o_tv_encoder_absent(),
    .o_tv_standard_select(),
    .o_periph_port_absent(),
    .o_periph_status_one(),
    .o_periph_status_zero(),
    .o_pad_pci()
  );
  rscl_strap_board i_board
  (
    .i_pulldown_fit(fit),
    .o_strap_pins(i_strap_pins)
  );
  // 50 MHz clock
  always #10 i_clk_sys = ~i_clk_sys;
  ////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one config read, answer one edge later
  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_clk_sys) #1;
    i_cfg_addr = a;
    i_cfg_rd = 1'b1;
    @(posedge i_clk_sys) #1;
    i_cfg_rd = 1'b0;
    rd = o_cfg_rdata;
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // per pattern: reset, capture, rework board, read back
  initial
  begin
    foreach (pat[k])
    begin
      p = pat[k];
      fit = ~p;
      i_arst_n = 1'b0;
      repeat (k ? 2 : 10) @(posedge i_clk_sys);
      #1 i_arst_n = 1'b1;
      repeat (3) @(posedge i_clk_sys);
      #1 fit = p;
      rd_reg(8'hEC);
      chk(rd, {5'h00, p});
      chk({o_int_allowed, o_int_line_enable}, {2{p[26]}});
      chk({o_rom_decode_enable, o_rom_bar_enable}, {2{p[25]}});
      chk({o_mem_channel_bypass}, {~p[24]});
      chk({o_mem_clock_test_bypass}, {~p[15]});
      chk({o_bus_agp, o_bus_agp_133, o_bus_pci_66},
        {p[6] & p[5], p[6:4] == 3'h6, p[6:4] == 3'h4});
      chk({o_bus_reserved, o_host_bus_select}, {~p[6], p[6:4]});
      chk({o_video_module_if_mode, o_vmi_enable, o_video_module_if_mode_a},
        {p[3:2], ~p[3], p[3:2] == 2'h1});
      chk({o_feature_conn_route}, {p[1]});
      chk({o_feature_conn_enable}, {p[0]});
      chk({o_vga_enable, o_subclass_bit7}, {2{p[23]}});
      chk({o_rom_size_64k, o_rom_bar_bit15}, {2{p[22]}});
      chk({o_video_clock_test_bypass}, {~p[21]});
      chk({o_periph_port_data_source}, {p[20]});
      chk({o_tv_encoder_absent, o_periph_status_one}, {2{p[19]}});
      chk({o_tv_standard_select}, {p[18]});
      chk({o_periph_port_absent, o_periph_status_zero}, {2{p[17]}});
      chk({o_pad_pci}, {p[16]});
      chk({early_rom_64k, early_mclk_byp}, {p[15], ~p[22]});
      rd_reg(8'h00);
      chk(rd, 32'h00000000);
    end
    tally_and_finish;
  end
  // watchdog against a stuck run
  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish;
  end
endmodule // test_rscl_strap_latch
bind rscl_strap_latch rscl_properties i_props (.*);
